// ==== design/spm_pkg.sv ====
// spm_pkg: constants, mode type and lane helpers for the protocol selector
// assumes: both link ends and the host register map import nothing, use spm_pkg::
package spm_pkg;

  // ********************************************************
  // link protocol modes
  // ********************************************************
  typedef enum logic [1:0] {
    MODE_EXT  = 2'b00,
    MODE_DUAL = 2'b01,
    MODE_QUAD = 2'b10
  } spm_mode_t;

  // ********************************************************
  // link command codes and configuration layout
  // ********************************************************
  localparam logic [7:0]  OP_WR_EVCR  = 8'h61;
  localparam logic [7:0]  OP_RD_EVCR  = 8'h65;
  localparam logic [7:0]  OP_WR_NVCR  = 8'hb1;
  localparam logic [7:0]  OP_RESCUE   = 8'hff;
  localparam logic [7:0]  EVCR_RST    = 8'hff;
  localparam logic [15:0] NVCR_RST    = 16'hffff;
  localparam int          EV_QUAD_N   = 7;
  localparam int          EV_DUAL_N   = 6;
  localparam int          NV_QUAD_N   = 3;
  localparam int          NV_DUAL_N   = 2;
  localparam int          NV_DUMMY_LO = 12;

  // ********************************************************
  // serial clock made by the host
  // ********************************************************
  localparam int          CLK_NS        = 10;
  localparam int          SCLK_HALF_NS  = 80;
  localparam int          SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;

  // ********************************************************
  // host register map and fields
  // ********************************************************
  localparam logic [11:0] ADDR_CMD   = 12'h000;
  localparam logic [11:0] ADDR_WDATA = 12'h004;
  localparam logic [11:0] ADDR_RDATA = 12'h008;
  localparam logic [11:0] ADDR_STAT  = 12'h00c;
  localparam logic [11:0] ADDR_CTRL  = 12'h010;
  localparam int          CMD_NB_LO  = 8;
  localparam int          CMD_RD_BIT = 10;
  localparam int          CTRL_VPP   = 2;

  // lines used per clock
  function automatic logic [2:0] lanes(spm_mode_t m);
    unique case (m)
      MODE_DUAL: lanes = 3'h2;
      MODE_QUAD: lanes = 3'h4;
      default:   lanes = 3'h1;
    endcase
  endfunction

  // top bits of a nibble placed on pins; in ext mode data out leaves on line 1
  function automatic logic [3:0] spread(spm_mode_t m, logic [3:0] t, logic miso);
    unique case (m)
      MODE_DUAL: spread = {2'h0, t[3:2]};
      MODE_QUAD: spread = t;
      default:   spread = miso ? {2'h0, t[3], 1'b0} : {3'h0, t[3]};
    endcase
  endfunction

  // pins driven for a given mode and direction
  function automatic logic [3:0] oe_mask(spm_mode_t m, logic miso);
    oe_mask = spread(m, 4'hf, miso);
  endfunction

  // bits gathered from pins, right aligned
  function automatic logic [3:0] gather(spm_mode_t m, logic [3:0] p, logic miso);
    unique case (m)
      MODE_DUAL: gather = {2'h0, p[1:0]};
      MODE_QUAD: gather = p;
      default:   gather = {3'h0, miso ? p[1] : p[0]};
    endcase
  endfunction

  // protocol chosen by a volatile configuration byte
  function automatic spm_mode_t ev_mode(logic [7:0] v);
    if (!v[EV_QUAD_N]) ev_mode = MODE_QUAD;
    else if (!v[EV_DUAL_N]) ev_mode = MODE_DUAL;
    else ev_mode = MODE_EXT;
  endfunction

endpackage

// ==== design/spm_link_if.sv ====
// spm_link_if: serial link between controller and memory end
// assumes: line level resolved here, idle lines read high
`timescale 1ns/1ps
interface spm_link_if;
  logic       sclk;
  logic       cs_n;
  logic       vpp;
  logic [3:0] dq_h_out;
  logic [3:0] dq_h_oe;
  logic [3:0] dq_d_out;
  logic [3:0] dq_d_oe;
  logic [3:0] dq;

  // wired level of each data line, pulled high when nobody drives
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      dq[i] = dq_h_oe[i] ? dq_h_out[i] : (dq_d_oe[i] ? dq_d_out[i] : 1'b1);
    end
  end

  modport host (output sclk, cs_n, vpp, dq_h_out, dq_h_oe, input dq);
  modport dev  (input sclk, cs_n, vpp, dq, output dq_d_out, dq_d_oe);
endinterface

// ==== design/spm_dev.sv ====
// spm_dev: memory end of the link, protocol select and configuration load
// assumes: link pins are asynchronous to pclk and pass two flip-flops
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module spm_dev (
  // system
  input  wire logic        pclk,
  input  wire logic        clk_en,
  input  wire logic        presetn,
  // nonvolatile cell erase, boot request, program/erase activity
  input  wire logic        nv_rst_n,
  input  wire logic        boot_req,
  input  wire logic        pe_busy,
  // link
  spm_link_if.dev          link,
  // state seen by the user side
  output spm_pkg::spm_mode_t frame_mode,
  output logic [7:0]       icr,
  output logic [7:0]       evcr,
  output logic [15:0]      nvcr
);

  // ********************************************************
  // declarations
  // ********************************************************
  logic              sclk_s1, sclk_s2, sclk_d;
  logic              cs_s1, cs_s2, cs_d;
  logic              vpp_s1, vpp_s2;
  logic [3:0]        dq_s1, dq_s2;
  logic              sclk_rise, sclk_fall, cs_fall, cs_rise;
  logic [7:0]        icr_reg, evcr_reg;
  logic [15:0]       nvcr_reg;
  logic              boot_pend_reg;
  spm_pkg::spm_mode_t fmode_reg, work_mode;
  logic [23:0]       sh_reg, sh_next;
  logic [5:0]        cnt_reg, cnt_next;
  logic [7:0]        cmd_reg;
  logic              rd_act_reg;
  logic [7:0]        tx_reg;
  logic [3:0]        dq_out_reg, dq_oe_reg;
  logic              wr_ev, rescue, wr_nv;

  // ********************************************************
  // pin synchronisers
  // ********************************************************

  // two stages per pin, a third on sclk and cs for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_d  <= 1'b0;
      cs_s1   <= 1'b1;
      cs_s2   <= 1'b1;
      cs_d    <= 1'b1;
      vpp_s1  <= 1'b0;
      vpp_s2  <= 1'b0;
      dq_s1   <= 4'hf;
      dq_s2   <= 4'hf;
    end else if (clk_en) begin
      sclk_s1 <= link.sclk;
      sclk_s2 <= sclk_s1;
      sclk_d  <= sclk_s2;
      cs_s1   <= link.cs_n;
      cs_s2   <= cs_s1;
      cs_d    <= cs_s2;
      vpp_s1  <= link.vpp;
      vpp_s2  <= vpp_s1;
      dq_s1   <= link.dq;
      dq_s2   <= dq_s1;
    end
  end

  // edge strobes from the settled stages
  assign sclk_rise = clk_en & sclk_s2 & ~sclk_d & ~cs_s2;
  assign sclk_fall = clk_en & ~sclk_s2 & sclk_d & ~cs_s2;
  assign cs_fall   = clk_en & ~cs_s2 & cs_d;
  assign cs_rise   = clk_en & cs_s2 & ~cs_d;

  // ********************************************************
  // protocol selection
  // ********************************************************

  // quad falls back to single while vpp is high during program/erase
  always_comb begin
    work_mode = spm_pkg::ev_mode(icr_reg);
    if (work_mode == spm_pkg::MODE_QUAD && vpp_s2 && pe_busy) begin
      work_mode = spm_pkg::MODE_EXT;
    end
  end

  // protocol frozen for a whole frame at chip select fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmode_reg <= spm_pkg::MODE_EXT;
    end else if (cs_fall) begin
      fmode_reg <= work_mode;
    end
  end

  // ********************************************************
  // receive shifter
  // ********************************************************

  // bits enter msb first, lanes per clock set by frame mode
  always_comb begin
    sh_next  = (sh_reg << spm_pkg::lanes(fmode_reg)) | 24'(spm_pkg::gather(fmode_reg, dq_s2, 1'b0));
    cnt_next = cnt_reg;
    if (cnt_reg < 6'h20) begin
      cnt_next = cnt_reg + 6'(spm_pkg::lanes(fmode_reg));
    end
  end

  // shift on rising sclk, clear at frame start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_reg  <= 24'h0;
      cnt_reg <= 6'h0;
    end else if (cs_fall) begin
      sh_reg  <= 24'h0;
      cnt_reg <= 6'h0;
    end else if (sclk_rise) begin
      sh_reg  <= sh_next;
      cnt_reg <= cnt_next;
    end
  end

  // command byte captured once eight bits are in
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg <= 8'h0;
    end else if (cs_fall) begin
      cmd_reg <= 8'h0;
    end else if (sclk_rise && cnt_next == 6'h8 && cnt_reg != 6'h8) begin
      cmd_reg <= sh_next[7:0];
    end
  end

  // ********************************************************
  // read-back of volatile configuration
  // ********************************************************

  // data leaves on falling sclk after the command byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_act_reg <= 1'b0;
      tx_reg     <= 8'h0;
      dq_out_reg <= 4'h0;
      dq_oe_reg  <= 4'h0;
    end else if (cs_rise || cs_fall) begin
      rd_act_reg <= 1'b0;
      dq_oe_reg  <= 4'h0;
    end else if (sclk_rise && cnt_next == 6'h8 && cnt_reg != 6'h8 && sh_next[7:0] == spm_pkg::OP_RD_EVCR) begin
      rd_act_reg <= 1'b1;
      tx_reg     <= evcr_reg;
    end else if (sclk_fall && rd_act_reg) begin
      dq_out_reg <= spm_pkg::spread(fmode_reg, tx_reg[7:4], 1'b1);
      dq_oe_reg  <= spm_pkg::oe_mask(fmode_reg, 1'b1);
      tx_reg     <= tx_reg << spm_pkg::lanes(fmode_reg);
    end
  end

  assign link.dq_d_out = dq_out_reg;
  assign link.dq_d_oe  = dq_oe_reg;

  // ********************************************************
  // command completion
  // ********************************************************

  // write and rescue commands act only at chip select rise on a whole byte count
  assign wr_ev  = cs_rise && cmd_reg == spm_pkg::OP_WR_EVCR && cnt_reg == 6'h10;
  assign wr_nv  = cs_rise && cmd_reg == spm_pkg::OP_WR_NVCR && cnt_reg == 6'h18;
  assign rescue = cs_rise && cmd_reg == spm_pkg::OP_RESCUE && cnt_reg == 6'h8;

  // boot pending from reset release or a boot request; a new request wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_pend_reg <= 1'b1;
    end else if (clk_en) begin
      boot_pend_reg <= boot_req;
    end
  end

  // working and volatile configuration: boot load, then live writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      icr_reg  <= spm_pkg::EVCR_RST;
      evcr_reg <= spm_pkg::EVCR_RST;
    end else if (clk_en) begin
      if (boot_pend_reg) begin
        icr_reg  <= {nvcr_reg[spm_pkg::NV_QUAD_N], nvcr_reg[spm_pkg::NV_DUAL_N] | ~nvcr_reg[spm_pkg::NV_QUAD_N],
                     2'h3, nvcr_reg[spm_pkg::NV_DUMMY_LO +: 4]};
        evcr_reg <= {nvcr_reg[spm_pkg::NV_QUAD_N], nvcr_reg[spm_pkg::NV_DUAL_N] | ~nvcr_reg[spm_pkg::NV_QUAD_N],
                     2'h3, nvcr_reg[spm_pkg::NV_DUMMY_LO +: 4]};
      end else if (wr_ev) begin
        icr_reg  <= sh_reg[7:0];
        evcr_reg <= sh_reg[7:0];
      end else if (rescue) begin
        icr_reg  <= icr_reg | 8'hc0;
        evcr_reg <= evcr_reg | 8'hc0;
      end
    end
  end

  // nonvolatile cells survive power-on, erased only by nv_rst_n
  always_ff @(posedge pclk or negedge nv_rst_n) begin
    if (!nv_rst_n) begin
      nvcr_reg <= spm_pkg::NVCR_RST;
    end else if (clk_en && wr_nv) begin
      nvcr_reg <= {sh_reg[7:0], sh_reg[15:8]};
    end
  end

  // ********************************************************
  // user side outputs
  // ********************************************************
  assign frame_mode = fmode_reg;
  assign icr        = icr_reg;
  assign evcr       = evcr_reg;
  assign nvcr       = nvcr_reg;

endmodule

// ==== design/spm_host.sv ====
// spm_host: controller end, APB registers drive frames on the link
// assumes: APB master per the usual two-phase protocol, device on spm_link_if
`timescale 1ns/1ps
module spm_host (
  // system
  input  wire logic        pclk,
  input  wire logic        clk_en,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  spm_link_if.host         link
);

  // ********************************************************
  // declarations
  // ********************************************************
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_TAIL = 2'b10} spm_hst_t;
  spm_hst_t           state_reg;
  spm_pkg::spm_mode_t mode_reg, fmode_reg, done_mode;
  logic               vpp_reg, done_set;
  logic [15:0]        wdata_reg;
  logic [7:0]         rdata_reg, op_reg;
  logic [31:0]        prdata_reg;
  logic [3:0]         dq_s1, dq_s2, dq_out_reg, dq_oe_reg;
  logic [23:0]        tx_reg;
  logic [7:0]         rx_reg;
  logic [4:0]         bits_reg, ntx_reg, total_reg;
  logic [4:0]         div_reg;
  logic               sclk_reg, cs_n_reg, wr_acc, start, mapped;
  logic [4:0]         ntx_new;

  localparam logic [4:0] HALF = 5'(spm_pkg::SCLK_HALF_CYC);

  // ********************************************************
  // apb slave, zero wait
  // ********************************************************
  assign mapped  = paddr == spm_pkg::ADDR_CMD || paddr == spm_pkg::ADDR_WDATA || paddr == spm_pkg::ADDR_RDATA ||
                   paddr == spm_pkg::ADDR_STAT || paddr == spm_pkg::ADDR_CTRL;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_reg;
  assign wr_acc  = clk_en & psel & penable & pwrite & mapped;
  assign start   = wr_acc && paddr == spm_pkg::ADDR_CMD && state_reg == ST_IDLE;
  assign ntx_new = 5'h8 + {pwdata[spm_pkg::CMD_NB_LO +: 2], 3'h0};

  // read data sampled in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
    end else if (clk_en && psel && !penable) begin
      unique case (paddr)
        spm_pkg::ADDR_WDATA: prdata_reg <= {16'h0, wdata_reg};
        spm_pkg::ADDR_RDATA: prdata_reg <= {24'h0, rdata_reg};
        spm_pkg::ADDR_STAT:  prdata_reg <= {29'h0, fmode_reg, state_reg != ST_IDLE};
        spm_pkg::ADDR_CTRL:  prdata_reg <= {29'h0, vpp_reg, mode_reg};
        default:             prdata_reg <= 32'h0;
      endcase
    end
  end

  // write data and vpp control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdata_reg <= 16'h0;
      vpp_reg   <= 1'b0;
    end else if (wr_acc && paddr == spm_pkg::ADDR_WDATA) begin
      wdata_reg <= pwdata[15:0];
    end else if (wr_acc && paddr == spm_pkg::ADDR_CTRL) begin
      vpp_reg <= pwdata[spm_pkg::CTRL_VPP];
    end
  end

  // ********************************************************
  // protocol tracking
  // ********************************************************

  // mode follows completed volatile writes and rescue frames
  assign done_set  = clk_en && state_reg == ST_TAIL && div_reg == HALF &&
                     ((op_reg == spm_pkg::OP_WR_EVCR && ntx_reg == 5'h10) || (op_reg == spm_pkg::OP_RESCUE && ntx_reg == 5'h8));
  assign done_mode = (op_reg == spm_pkg::OP_RESCUE) ? spm_pkg::MODE_EXT : spm_pkg::ev_mode(wdata_reg[7:0]);

  // hardware update wins over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= spm_pkg::MODE_EXT;
    end else if (done_set) begin
      mode_reg <= done_mode;
    end else if (wr_acc && paddr == spm_pkg::ADDR_CTRL && pwdata[1:0] != 2'h3) begin
      mode_reg <= spm_pkg::spm_mode_t'(pwdata[1:0]);
    end
  end

  // ********************************************************
  // frame engine
  // ********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_s1 <= 4'hf;
      dq_s2 <= 4'hf;
    end else if (clk_en) begin
      dq_s1 <= link.dq;
      dq_s2 <= dq_s1;
    end
  end

  // cs low, then a clock per lane group, data out on low phase, in on high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg  <= ST_IDLE;
      fmode_reg  <= spm_pkg::MODE_EXT;
      op_reg     <= 8'h0;
      tx_reg     <= 24'h0;
      rx_reg     <= 8'h0;
      rdata_reg  <= 8'h0;
      bits_reg   <= 5'h0;
      ntx_reg    <= 5'h0;
      total_reg  <= 5'h0;
      div_reg    <= 5'h0;
      sclk_reg   <= 1'b0;
      cs_n_reg   <= 1'b1;
      dq_out_reg <= 4'h0;
      dq_oe_reg  <= 4'h0;
    end else if (clk_en) begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start) begin
            fmode_reg <= (mode_reg == spm_pkg::MODE_QUAD && vpp_reg) ? spm_pkg::MODE_EXT : mode_reg;
            op_reg    <= pwdata[7:0];
            tx_reg    <= {pwdata[7:0], wdata_reg[7:0], wdata_reg[15:8]};
            ntx_reg   <= ntx_new;
            total_reg <= ntx_new + (pwdata[spm_pkg::CMD_RD_BIT] ? 5'h8 : 5'h0);
            bits_reg  <= 5'h0;
            div_reg   <= 5'h0;
            cs_n_reg  <= 1'b0;
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          div_reg <= (div_reg == 2 * HALF - 5'h1) ? 5'h0 : div_reg + 5'h1;
          if (div_reg == 5'h0) begin
            sclk_reg <= 1'b0;
            if (bits_reg == total_reg) begin
              dq_oe_reg <= 4'h0;
              state_reg <= ST_TAIL;
              div_reg   <= 5'h0;
            end else if (bits_reg < ntx_reg) begin
              dq_out_reg <= spm_pkg::spread(fmode_reg, tx_reg[23:20], 1'b0);
              dq_oe_reg  <= spm_pkg::oe_mask(fmode_reg, 1'b0);
              tx_reg     <= tx_reg << spm_pkg::lanes(fmode_reg);
            end else begin
              dq_oe_reg <= 4'h0;
            end
          end else if (div_reg == HALF) begin
            sclk_reg <= 1'b1;
            bits_reg <= bits_reg + 5'(spm_pkg::lanes(fmode_reg));
            if (bits_reg >= ntx_reg) begin
              rx_reg <= (rx_reg << spm_pkg::lanes(fmode_reg)) | 8'(spm_pkg::gather(fmode_reg, dq_s2, 1'b1));
            end
          end
        end
        ST_TAIL: begin
          div_reg <= div_reg + 5'h1;
          if (div_reg == HALF) begin
            cs_n_reg  <= 1'b1;
            rdata_reg <= rx_reg;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign link.sclk     = sclk_reg;
  assign link.cs_n     = cs_n_reg;
  assign link.vpp      = vpp_reg;
  assign link.dq_h_out = dq_out_reg;
  assign link.dq_h_oe  = dq_oe_reg;

endmodule

// ==== bench/spm_link_sva.sv ====
// spm_link_sva: assertions on the link and on the device configuration state
// assumes: instantiated beside the link interface, everything on pclk
`timescale 1ns/1ps
module spm_link_sva (
  // system
  input wire logic               pclk,
  input wire logic               presetn,
  // link
  input wire logic               cs_n,
  input wire logic               vpp,
  input wire logic [3:0]         dq_h_oe,
  input wire logic [3:0]         dq_d_oe,
  // device state
  input wire spm_pkg::spm_mode_t frame_mode,
  input wire logic [7:0]         icr,
  input wire logic [7:0]         evcr,
  input wire logic [15:0]        nvcr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ********************************************************
  // lines used inside a settled frame
  // ********************************************************
  ext_lanes_a: assert property ((!cs_n)[*8] ##0 (frame_mode == spm_pkg::MODE_EXT) |->
    (dq_h_oe & 4'he) == 4'h0 && (dq_d_oe & 4'hd) == 4'h0) else $error("ext frame drives extra lines");
  dual_lanes_a: assert property ((!cs_n)[*8] ##0 (frame_mode == spm_pkg::MODE_DUAL) |->
    ((dq_h_oe | dq_d_oe) & 4'hc) == 4'h0) else $error("dual frame drives lines 3 or 2");
  quad_lanes_a: assert property ((!cs_n)[*8] ##0 (frame_mode == spm_pkg::MODE_QUAD) |->
    dq_h_oe inside {4'h0, 4'hf} && dq_d_oe inside {4'h0, 4'hf}) else $error("quad frame uses partial lines");

  // ********************************************************
  // protocol chosen at frame start from volatile bits
  // ********************************************************
  frame_quad_a: assert property ($fell(cs_n) && !evcr[7] && !vpp |->
    ##[1:8] frame_mode == spm_pkg::MODE_QUAD) else $error("quad not selected");
  frame_dual_a: assert property ($fell(cs_n) && evcr[7:6] == 2'b10 |->
    ##[1:8] frame_mode == spm_pkg::MODE_DUAL) else $error("dual not selected");
  frame_ext_a: assert property ($fell(cs_n) && evcr[7:6] == 2'b11 |->
    ##[1:8] frame_mode == spm_pkg::MODE_EXT) else $error("ext not selected");

  // ********************************************************
  // configuration loading
  // ********************************************************
  boot_load_a: assert property ($rose(presetn) |-> ##2 (!nvcr[3] ? !evcr[7] :
    (evcr[7:6] == (nvcr[2] ? 2'b11 : 2'b10)))) else $error("boot protocol not from nonvolatile");
  ev_copy_a: assert property ($changed(evcr) |-> ##[0:2] icr[7:4] == evcr[7:4])
    else $error("working config missed volatile write");

  // main scenarios seen
  cover property (frame_mode == spm_pkg::MODE_DUAL && !cs_n);
  cover property (frame_mode == spm_pkg::MODE_QUAD && !cs_n);
  cover property (vpp && !cs_n && frame_mode == spm_pkg::MODE_EXT);
endmodule

// ==== bench/spi_protocol_mode_select_bench.sv ====
// spi_protocol_mode_select_bench: host and device ends joined, driven over apb
// assumes: package, link interface, both ends and checker compiled first
`timescale 1ns/1ps
module spi_protocol_mode_select_bench;
  logic               pclk, presetn, nv_rst_n, boot_req, pe_busy;
  logic               psel, penable, pwrite, pready, pslverr;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic [7:0]         icr, evcr;
  logic [15:0]        nvcr;
  spm_pkg::spm_mode_t frame_mode;
  int                 bad_count, n_checks, cyc;
  spm_link_if         lnk ();

  // ********************************************************
  // both ends and the checker
  // ********************************************************
  spm_host u_spm_host (.pclk(pclk), .clk_en(1'b1), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(lnk.host));
  spm_dev u_spm_dev (.pclk(pclk), .clk_en(1'b1), .presetn(presetn), .nv_rst_n(nv_rst_n), .boot_req(boot_req),
    .pe_busy(pe_busy), .link(lnk.dev), .frame_mode(frame_mode), .icr(icr), .evcr(evcr), .nvcr(nvcr));
  spm_link_sva u_spm_link_sva (.pclk(pclk), .presetn(presetn), .cs_n(lnk.cs_n), .vpp(lnk.vpp),
    .dq_h_oe(lnk.dq_h_oe), .dq_d_oe(lnk.dq_d_oe), .frame_mode(frame_mode), .icr(icr), .evcr(evcr), .nvcr(nvcr));

  // clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      conclude();
    end
  end

  // ********************************************************
  // shared tasks
  // ********************************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // access phase: answer and read data taken at the edge that sees pready high
    do @(posedge pclk); while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic frame(input logic [10:0] cmd, input logic [15:0] wd);
    logic e;
    apb(1'b1, spm_pkg::ADDR_WDATA, {16'h0, wd}, e);
    apb(1'b1, spm_pkg::ADDR_CMD, {21'h0, cmd}, e);
    // a frame that never ends is caught by the hang guard
    do apb(1'b0, spm_pkg::ADDR_STAT, 32'h0, e); while (rd[0] !== 1'b0);
    repeat (8) @(posedge pclk);
  endtask
  task automatic set_ev(input logic [7:0] v);
    frame({3'b001, spm_pkg::OP_WR_EVCR}, {8'h0, v});
  endtask
  task automatic set_nv(input logic [15:0] v);
    frame({3'b010, spm_pkg::OP_WR_NVCR}, v);
  endtask
  task automatic ctrl(input logic [2:0] v);
    logic e;
    apb(1'b1, spm_pkg::ADDR_CTRL, {29'h0, v}, e);
  endtask
  task automatic reboot();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  // read volatile config back over the link and compare frame mode at both ends
  task automatic probe(input spm_pkg::spm_mode_t m, input logic [7:0] ev, input logic [7:0] msk);
    logic e;
    frame({3'b100, spm_pkg::OP_RD_EVCR}, 16'h0);
    apb(1'b0, spm_pkg::ADDR_RDATA, 32'h0, e);
    chk("rdata", {24'h0, ev & msk}, {24'h0, rd[7:0] & msk});
    chk("icr", {24'h0, ev & msk & 8'hf0}, {24'h0, icr & msk & 8'hf0});
    apb(1'b0, spm_pkg::ADDR_STAT, 32'h0, e);
    chk("stat_mode", {30'h0, m}, {30'h0, rd[2:1]});
    chk("frame_mode", {30'h0, m}, {30'h0, frame_mode});
  endtask

  // ********************************************************
  // scenarios
  // ********************************************************
  task automatic t_default();
    chk("nvcr", 32'h0000ffff, {16'h0, nvcr});
    probe(spm_pkg::MODE_EXT, 8'hff, 8'hff);
  endtask
  task automatic t_volatile();
    set_ev(8'hbf);
    probe(spm_pkg::MODE_DUAL, 8'hbf, 8'hff);
    set_ev(8'h7f);
    probe(spm_pkg::MODE_QUAD, 8'h7f, 8'hff);
    frame({3'b000, spm_pkg::OP_RESCUE}, 16'h0);
    probe(spm_pkg::MODE_EXT, 8'hff, 8'hff);
    set_ev(8'h3f);
    probe(spm_pkg::MODE_QUAD, 8'h3f, 8'hff);
    set_ev(8'hff);
    probe(spm_pkg::MODE_EXT, 8'hff, 8'hff);
  endtask
  task automatic t_nonvol();
    set_nv(16'hfffb);
    chk("nvcr", 32'h0000fffb, {16'h0, nvcr});
    set_ev(8'h7f);
    probe(spm_pkg::MODE_QUAD, 8'h7f, 8'hff);
    reboot();
    ctrl(3'b001);
    probe(spm_pkg::MODE_DUAL, 8'h80, 8'hc0);
    set_nv(16'hfff7);
    @(posedge pclk);
    boot_req <= 1'b1;
    @(posedge pclk);
    boot_req <= 1'b0;
    repeat (4) @(posedge pclk);
    ctrl(3'b010);
    probe(spm_pkg::MODE_QUAD, 8'h00, 8'h80);
  endtask
  task automatic t_vpp();
    pe_busy <= 1'b1;
    ctrl(3'b110);
    probe(spm_pkg::MODE_EXT, 8'h00, 8'h80);
    pe_busy <= 1'b0;
    ctrl(3'b010);
    probe(spm_pkg::MODE_QUAD, 8'h00, 8'h80);
  endtask
  task automatic t_restore();
    logic e;
    @(posedge pclk);
    nv_rst_n <= 1'b0;
    @(posedge pclk);
    nv_rst_n <= 1'b1;
    reboot();
    chk("nvcr", 32'h0000ffff, {16'h0, nvcr});
    probe(spm_pkg::MODE_EXT, 8'hff, 8'hff);
    apb(1'b0, 12'h020, 32'h0, e);
    chk("slverr", 32'h1, {31'h0, e});
    chk("unmapped_rd", 32'h0, rd);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    presetn = 1'b0;
    nv_rst_n = 1'b0;
    boot_req = 1'b0;
    pe_busy = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    nv_rst_n <= 1'b1;
    repeat (3) @(posedge pclk);
    t_default();
    t_volatile();
    t_nonvol();
    t_vpp();
    t_restore();
    conclude();
  end
endmodule
